// >>> hdl/sotp_pkg.sv
// sotp_pkg: constants and types for the secured OTP lock control block.
// assumes a serial flash core around it that owns the array and program engine.
package sotp_pkg;

  // command bytes
  localparam logic [7:0] SOTP_CMD_WR_SEC = 8'h2F;
  localparam logic [7:0] SOTP_CMD_RD_SEC = 8'h2B;
  localparam logic [7:0] SOTP_CMD_ENTRY  = 8'hB1;
  localparam logic [7:0] SOTP_CMD_EXIT   = 8'hC1;

  // security register layout
  localparam int         SOTP_FACTORY_BIT = 0;
  localparam int         SOTP_LOCK_BIT    = 1;
  localparam logic [5:0] SOTP_SEC_RSVD    = 6'h00;

  // otp address map, 4K bits
  localparam logic [23:0] SOTP_SERIAL_LO = 24'h00_0000;
  localparam logic [23:0] SOTP_SERIAL_HI = 24'h00_000F;
  localparam logic [23:0] SOTP_AREA_HI   = 24'h00_01FF;

  // frame bit counter
  localparam int         SOTP_CNT_W    = 7;
  localparam logic [6:0] SOTP_CNT_MAX  = 7'h7F;
  localparam logic [6:0] SOTP_CNT_WRAP = 7'h78;
  localparam logic [6:0] SOTP_BITS_1B  = 7'h08;
  localparam logic [6:0] SOTP_BITS_2B  = 7'h10;

  // reset values
  localparam logic       SOTP_RST_LOCK = 1'b0;
  localparam logic       SOTP_RST_MODE = 1'b0;

  // frame captured on the link side, read after chip select rises
  typedef struct packed {
    logic [7:0]            opcode;
    logic [7:0]            data;
    logic [SOTP_CNT_W-1:0] bits;
  } sotp_frame_t;

  // program request from the flash core
  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } sotp_prg_t;

  typedef enum logic [1:0] {
    SOTP_ST_RESET,
    SOTP_ST_LOAD,
    SOTP_ST_RUN
  } sotp_state_t;

endpackage

// >>> hdl/sotp_lock_ctrl.sv
// sotp_lock_ctrl: secured OTP lock control, security register commands and
// otp mode, with the serial shifter on the link clock.
// assumes SCK is the host's serial clock (mode 0/3, stops outside frames)
// and that the flash core sends its program requests on CLK.
//
// Summary of operation
// [R1] command 2Fh loads security register bits from the following data byte; ignored here while in otp mode
// [R2] security register write needs no prior write enable
// [R3] customer write can only change bit1, the otp lockdown bit
// [R4] once lockdown bit is 1, every otp program is refused
// [R5] security write executes only if chip select rises at a byte boundary
// [R6] bit0 reports factory lock: 1 locked, 0 not locked
// [R7] host enters otp mode, page programs, then exits otp mode
// [R8] in otp mode all main array writes are blocked
// [R9] otp space 4K bits: 000-00F serial field, 010-1FF remaining area
// [R10] factory or customer lock is permanent, never cleared
// [R11] host waits the power-up write delay, up to 10 ms, before writing
// [R12] command B1h enters otp mode, redirecting read and program
// [R13] command C1h exits otp mode back to the main array
// [R14] command 2Bh returns the security register at any time
`timescale 1ns/10ps
module sotp_lock_ctrl
  import sotp_pkg::*;
(
  // system
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // serial link
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  output logic             SO,
  output logic             SO_OE_N,
  // nonvolatile lock state from the fuse store, asynchronous; lock burn pulse back to it on CLK
  input  wire logic        FACTORY_LOCK_NV,
  input  wire logic        CUST_LOCK_NV,
  output logic             CUST_LOCK_PROG,
  // flash core program path
  input  wire logic        PRG_REQ,
  input  wire logic [23:0] PRG_ADDR,
  output logic             PRG_GRANT,
  output logic             PRG_DENY,
  output logic             PRG_SERIAL_FIELD,
  output logic             OTP_MODE,
  output logic             ARRAY_WR_BLOCK
);

  // ---------------- link domain ----------------
  logic                  started_q;
  logic [SOTP_CNT_W-1:0] cnt_q, cnt_d, cur_cnt;
  logic [7:0]            sh_q, sh_d;
  logic [7:0]            opc_q, opc_d, dat_q, dat_d;
  logic [1:0]            sec_s1_q, sec_s2_q;
  logic                  so_q, so_d, oe_n_q, oe_n_d;
  logic [7:0]            sec_link;
  logic [2:0]            rd_idx;
  // system side lock flops, declared here as the link side samples them
  logic                  factory_q, factory_d, cust_lock_q, cust_lock_d;

  // chip select high ends the frame without needing a clock edge
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
      started_q <= 1'b0;
    else
      started_q <= 1'b1;
  end

  always_comb
  begin
    cur_cnt = started_q ? cnt_q : '0;
    sh_d    = {sh_q[6:0], SI};
    cnt_d   = (cur_cnt == SOTP_CNT_MAX) ? SOTP_CNT_WRAP : cur_cnt + 7'h01;
    opc_d   = opc_q;
    dat_d   = dat_q;
    if (cur_cnt[2:0] == 3'h7 && cur_cnt[6:3] == 4'h0)
      opc_d = sh_d;
    if (cur_cnt[2:0] == 3'h7 && cur_cnt[6:3] == 4'h1)
      dat_d = sh_d;
  end

  // frame contents hold after the frame, read from the system side
  always_ff @(posedge SCK)
  begin
    cnt_q <= cnt_d;
    sh_q  <= sh_d;
    opc_q <= opc_d;
    dat_q <= dat_d;
  end

  // lock state is a slow level; two stages before use
  always_ff @(posedge SCK)
  begin
    sec_s1_q <= {cust_lock_q, factory_q};
    sec_s2_q <= sec_s1_q;
  end

  assign sec_link = {SOTP_SEC_RSVD, sec_s2_q};
  assign rd_idx   = 3'h7 - cnt_q[2:0];

  always_comb
  begin
    so_d   = so_q;
    oe_n_d = 1'b1;
    // [R14] readout not gated by busy
    if (started_q && cnt_q >= SOTP_BITS_1B && opc_q == SOTP_CMD_RD_SEC)
    begin
      so_d   = sec_link[rd_idx];
      oe_n_d = 1'b0;
    end
  end

  always_ff @(negedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      so_q   <= so_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign SO      = so_q;
  assign SO_OE_N = oe_n_q;

  // ---------------- system domain ----------------
  logic [2:0]  cs_sync_q;
  logic [1:0]  fac_sync_q, cust_sync_q;
  sotp_state_t st_q, st_d;
  logic        mode_q, mode_d, lock_prog_q, lock_prog_d;
  logic        grant_q, grant_d, deny_q, deny_d, serial_q, serial_d;
  sotp_frame_t frm;
  logic        frame_end, on_byte, locked;
  sotp_prg_t   prg;

  always_ff @(posedge CLK)
  begin
    cs_sync_q   <= {cs_sync_q[1:0], CS_N};
    fac_sync_q  <= {fac_sync_q[0], FACTORY_LOCK_NV};
    cust_sync_q <= {cust_sync_q[0], CUST_LOCK_NV};
  end

  // frame regs are stable by the time the synced rise is seen
  assign frm       = '{opcode: opc_q, data: dat_q, bits: cnt_q};
  assign frame_end = cs_sync_q[1] && !cs_sync_q[2];
  assign on_byte   = (frm.bits[2:0] == 3'h0);
  assign locked    = cust_lock_q | factory_q;
  assign prg       = '{req: PRG_REQ, addr: PRG_ADDR};

  always_comb
  begin
    st_d        = st_q;
    factory_d   = factory_q;
    cust_lock_d = cust_lock_q;
    mode_d      = mode_q;
    lock_prog_d = 1'b0;
    grant_d     = 1'b0;
    deny_d      = 1'b0;
    serial_d    = 1'b0;
    case (st_q)
      SOTP_ST_RESET:
        st_d = SOTP_ST_LOAD;
      SOTP_ST_LOAD:
      begin
        // [R6] factory indicator from fuse
        factory_d   = fac_sync_q[1];
        cust_lock_d = cust_sync_q[1];
        st_d        = SOTP_ST_RUN;
      end
      SOTP_ST_RUN:
      begin
        if (frame_end && on_byte)
        begin
          // [R1] [R2] no write enable check
          // [R5] byte boundary required
          if (frm.opcode == SOTP_CMD_WR_SEC && frm.bits >= SOTP_BITS_2B && !mode_q)
          begin
            // [R3] [R10] only bit1, set only
            if (frm.data[SOTP_LOCK_BIT] && !cust_lock_q)
            begin
              cust_lock_d = 1'b1;
              lock_prog_d = 1'b1;
            end
          end
          // [R12] enter otp mode
          if (frm.opcode == SOTP_CMD_ENTRY && frm.bits >= SOTP_BITS_1B)
            mode_d = 1'b1;
          // [R13] back to main array
          if (frm.opcode == SOTP_CMD_EXIT && frm.bits >= SOTP_BITS_1B)
            mode_d = 1'b0;
        end
        if (prg.req)
        begin
          // [R4] [R9] otp program only unlocked and in range
          if (mode_q && (locked || prg.addr > SOTP_AREA_HI))
            deny_d = 1'b1;
          else
            grant_d = 1'b1;
          serial_d = mode_q && prg.addr >= SOTP_SERIAL_LO && prg.addr <= SOTP_SERIAL_HI;
        end
      end
      default:
        st_d = SOTP_ST_RESET;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_q        <= SOTP_ST_RESET;
      factory_q   <= SOTP_RST_LOCK;
      cust_lock_q <= SOTP_RST_LOCK;
      mode_q      <= SOTP_RST_MODE;
      lock_prog_q <= 1'b0;
      grant_q     <= 1'b0;
      deny_q      <= 1'b0;
      serial_q    <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      factory_q   <= factory_d;
      cust_lock_q <= cust_lock_d;
      mode_q      <= mode_d;
      lock_prog_q <= lock_prog_d;
      grant_q     <= grant_d;
      deny_q      <= deny_d;
      serial_q    <= serial_d;
    end
  end

  assign CUST_LOCK_PROG   = lock_prog_q;
  assign PRG_GRANT        = grant_q;
  assign PRG_DENY         = deny_q;
  assign PRG_SERIAL_FIELD = serial_q;
  assign OTP_MODE         = mode_q;
  // [R8] array writes blocked in otp mode
  assign ARRAY_WR_BLOCK   = mode_q;

endmodule

// >>> tb/sotp_host_model.sv
// sotp_host_model: serial host issuing one frame per call.
// assumes mode 0, 30 ns link clock that stands low between frames.
`timescale 1ns/10ps
module sotp_host_model (
  // link
  output logic     cs_n,
  output logic     sck,
  output logic     si,
  input  wire logic so
);
  initial
  begin
    sck  = 1'b0;
    si   = 1'b0;
    // late rise so the link flops surely see a clearing edge
    #1 cs_n = 1'b1;
  end
  task automatic frame(input logic [15:0] tx, input int nb, output logic [7:0] rx);
    rx   = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      si = tx[15-i];
      #15 sck = 1'b1;
      rx = {rx[6:0], so};
      #15 sck = 1'b0;
    end
    #5 cs_n = 1'b1;
    // released line must not look held
    si = ~si;
    #120;
  endtask
endmodule

// >>> tb/sotp_lock_ctrl_sva.sv
// sotp_lock_ctrl_sva: port checks for sotp_lock_ctrl on CLK.
// lock model follows burn pulses only; stored or factory locks not modelled.
`timescale 1ns/10ps
module sotp_lock_ctrl_sva (
  // system
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // link and program path
  input wire logic        CS_N,
  input wire logic        SO_OE_N,
  input wire logic        CUST_LOCK_PROG,
  input wire logic        PRG_REQ,
  input wire logic [23:0] PRG_ADDR,
  input wire logic        PRG_GRANT,
  input wire logic        PRG_DENY,
  input wire logic        PRG_SERIAL_FIELD,
  input wire logic        OTP_MODE,
  input wire logic        ARRAY_WR_BLOCK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic lock_q;
  logic lock_d;
  always_comb lock_d = (lock_q | CUST_LOCK_PROG) & ~SYS_RST;
  always_ff @(posedge CLK) lock_q <= lock_d;
  sequence s_otp_req;
    PRG_REQ && OTP_MODE;
  endsequence
  AST_BLOCK: assert property (ARRAY_WR_BLOCK == OTP_MODE)
    else $error("array block differs from otp mode");
  AST_ONE_ANSWER: assert property (PRG_REQ |=> PRG_GRANT != PRG_DENY)
    else $error("program request lacks one answer");
  AST_ARRAY_GRANT: assert property (PRG_REQ && !OTP_MODE |=> PRG_GRANT && !PRG_SERIAL_FIELD)
    else $error("array program not granted");
  AST_RANGE: assert property (s_otp_req ##0 PRG_ADDR > 24'h00_01FF |=> PRG_DENY)
    else $error("otp program beyond area granted");
  AST_SERIAL: assert property (s_otp_req ##0 PRG_ADDR <= 24'h00_000F |=> PRG_SERIAL_FIELD)
    else $error("serial field not flagged");
  AST_LOCKED: assert property (s_otp_req ##0 lock_q |=> PRG_DENY)
    else $error("otp program granted after lock");
  AST_PULSE: assert property (CUST_LOCK_PROG |=> !CUST_LOCK_PROG)
    else $error("lock burn pulse too long");
  AST_PROG_CS: assert property (CUST_LOCK_PROG |-> $past(CS_N, 2) && !OTP_MODE)
    else $error("lock burn outside closed frame");
  AST_MODE_CS: assert property ($changed(OTP_MODE) |-> $past(CS_N, 2))
    else $error("otp mode changed inside frame");
  AST_OE: assert property (CS_N |-> SO_OE_N)
    else $error("output driven while deselected");
endmodule
bind sotp_lock_ctrl sotp_lock_ctrl_sva sotp_lock_ctrl_sva_inst (.CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
  .SO_OE_N(SO_OE_N), .CUST_LOCK_PROG(CUST_LOCK_PROG), .PRG_REQ(PRG_REQ), .PRG_ADDR(PRG_ADDR),
  .PRG_GRANT(PRG_GRANT), .PRG_DENY(PRG_DENY), .PRG_SERIAL_FIELD(PRG_SERIAL_FIELD),
  .OTP_MODE(OTP_MODE), .ARRAY_WR_BLOCK(ARRAY_WR_BLOCK));

// >>> tb/sotp_lock_ctrl_bench.sv
// sotp_lock_ctrl_bench: self-checking bench for sotp_lock_ctrl.
// assumes the host model as far side; fuse levels set at each reset.
`timescale 1ns/10ps
module sotp_lock_ctrl_bench;
  import sotp_pkg::*;
  logic        clk, sys_rst, cs_n, sck, si, so, so_oe_n, fac_nv, prg_req;
  logic        cust_prog, grant, deny, serial, otp_mode, blk, cust_nv;
  logic [23:0] prg_addr;
  logic [7:0]  rx;
  int          errors, n_checks, cycles, n_prog;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sotp_host_model host_inst (.cs_n(cs_n), .sck(sck), .si(si), .so(so_oe_n ? ~so : so));
  sotp_lock_ctrl sotp_lock_ctrl_inst (.CLK(clk), .SYS_RST(sys_rst), .SCK(sck), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE_N(so_oe_n), .FACTORY_LOCK_NV(fac_nv), .CUST_LOCK_NV(cust_nv), .CUST_LOCK_PROG(cust_prog),
    .PRG_REQ(prg_req), .PRG_ADDR(prg_addr), .PRG_GRANT(grant), .PRG_DENY(deny),
    .PRG_SERIAL_FIELD(serial), .OTP_MODE(otp_mode), .ARRAY_WR_BLOCK(blk));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input logic [7:0] dat, input int nb);
    // off the clk edge so chip select never races the sync flops
    @(posedge clk);
    #1.3;
    host_inst.frame({op, dat}, nb, rx);
  endtask
  task automatic do_reset(input logic fac, input logic cust);
    @(posedge clk);
    fac_nv  <= fac;
    cust_nv <= cust;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // write delay scaled down, block does not time it
    repeat (4) @(posedge clk);
  endtask
  // answer packed as grant, deny, serial field
  task automatic prg(input logic [23:0] a, input logic [2:0] exp);
    @(posedge clk);
    prg_req  <= 1'b1;
    prg_addr <= a;
    @(posedge clk);
    prg_req <= 1'b0;
    #1 chk("program answer", {5'h00, grant, deny, serial}, {5'h00, exp});
  endtask
  task automatic sc_factory();
    do_reset(1'b1, 1'b0);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("factory set", rx, 8'h01);
    send(SOTP_CMD_ENTRY, 8'h00, 8);
    prg(24'h00_0010, 3'h2);
    send(SOTP_CMD_EXIT, 8'h00, 8);
    do_reset(1'b0, 1'b0);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("factory clear", rx, 8'h00);
  endtask
  task automatic sc_mode();
    send(SOTP_CMD_ENTRY, 8'h00, 8);
    chk("mode on", {6'h00, otp_mode, blk}, 8'h03);
    prg(24'h00_0005, 3'h5);
    prg(24'h00_01FF, 3'h4);
    prg(24'h00_0200, 3'h2);
    send(SOTP_CMD_WR_SEC, 8'h02, 16);
    send(SOTP_CMD_EXIT, 8'h00, 8);
    chk("mode off", {6'h00, otp_mode, blk}, 8'h00);
    prg(24'h00_0200, 3'h4);
  endtask
  task automatic sc_boundary();
    send(SOTP_CMD_WR_SEC, 8'h02, 12);
    send(SOTP_CMD_WR_SEC, 8'h02, 15);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("off boundary", rx | n_prog[7:0], 8'h00);
  endtask
  task automatic sc_lock();
    send(SOTP_CMD_WR_SEC, 8'hFF, 16);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("lock set", rx, 8'h02);
    send(SOTP_CMD_ENTRY, 8'h00, 8);
    prg(24'h00_0010, 3'h2);
    send(SOTP_CMD_EXIT, 8'h00, 8);
    send(SOTP_CMD_WR_SEC, 8'h00, 16);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("lock kept", rx, 8'h02);
    chk("burn pulses", n_prog[7:0], 8'h01);
  endtask
  // stored customer lock reloaded from its fuse after reset
  task automatic sc_stored();
    do_reset(1'b0, 1'b1);
    send(SOTP_CMD_RD_SEC, 8'h00, 16);
    chk("stored lock", rx, 8'h02);
    send(SOTP_CMD_WR_SEC, 8'h02, 16);
    send(SOTP_CMD_ENTRY, 8'h00, 8);
    prg(24'h00_0003, 3'h3);
    send(SOTP_CMD_EXIT, 8'h00, 8);
    chk("stored no burn", n_prog[7:0], 8'h01);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cust_prog === 1'b1)
      n_prog++;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end
  initial
  begin
    sys_rst  = 1'b1;
    fac_nv   = 1'b0;
    cust_nv  = 1'b0;
    prg_req  = 1'b0;
    prg_addr = 24'h00_0000;
    sc_factory();
    sc_mode();
    sc_boundary();
    sc_lock();
    sc_stored();
    complete_run();
  end
endmodule
